/* hw/adcc_defs.vh */
// Constants for the converter controller: register map, fields, timing
//
// Summary of operation
// - Eight channels, twelve-bit result per conversion
// - Single or continuous, software or pin start
// - Timer overflow starts conversion when enabled
// - Low convert pin starts conversion when enabled
// - Streaming mode converts continuously into external memory
// - Factory calibration loaded automatically at power-up
// - Offset and gain registers, software overwritable
// - Temperature reference selectable as ninth input
// - Straight binary coding, step is full scale/4096
// - Result in high/low, channel in top nibble
// - Mode bits pick down, normal, down-idle, standby-idle
// - Down turns all off; standby keeps reference
// - Clock divide 1, 2, 4 or 8
// - Conversion takes seventeen converter clocks
// - Acquisition lasts 1, 2, 4 or 8 clocks
// - Timing and mode register resets to 20h
// - Configuration reachable through function register interface
// - Done flag set on single or block end
// - Done flag cleared when interrupt is vectored
// - Continuous bit restarts after each completion
// - Channel taken from select bits at start
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

`define ADCC_ADDR_TMC     8'hef
`define ADCC_ADDR_CTL     8'hd8
`define ADCC_ADDR_RESH    8'hda
`define ADCC_ADDR_RESL    8'hd9
`define ADCC_ADDR_OFFS    8'hf1
`define ADCC_ADDR_GAIN    8'hf2

`define ADCC_TMC_RESET    8'h20
`define ADCC_CTL_RESET    8'h00

`define ADCC_TMC_MODE_HI  7
`define ADCC_TMC_MODE_LO  6
`define ADCC_TMC_DIV_HI   5
`define ADCC_TMC_DIV_LO   4
`define ADCC_TMC_ACQ_HI   3
`define ADCC_TMC_ACQ_LO   2
`define ADCC_TMC_TIMER    1
`define ADCC_TMC_PIN      0

`define ADCC_CTL_DONE     7
`define ADCC_CTL_STREAM   6
`define ADCC_CTL_CONT     5
`define ADCC_CTL_SINGLE   4

`define ADCC_MODE_DOWN    2'h0
`define ADCC_MODE_NORMAL  2'h1
`define ADCC_MODE_DOWNIDL 2'h2
`define ADCC_MODE_STBYIDL 2'h3

`define ADCC_CONV_CLKS    5'h11
`define ADCC_PWRUP_CLKS   4'h2
`define ADCC_ADDR_LAST    24'hffffff

`endif

/* hw/adcc_ctrl.v */
// Converter conversion controller with its sample FIFO
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defs.vh"

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module adcc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             nrst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule // adcc_fifo

// ----------------------------------------
// Controller
// ----------------------------------------
module adcc_ctrl (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_wr,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata,
    input  wire        irq_ack,
    output wire        irq_req,
    input  wire        timer_overflow,
    input  wire        external_convert_start_n,
    input  wire [7:0]  factory_offset,
    input  wire [7:0]  factory_gain,
    output reg         core_power_on,
    output reg         core_ref_on,
    output reg         core_clk_tick,
    output reg         core_track,
    output reg         core_convert,
    output reg  [3:0]  core_mux_sel,
    output reg  [7:0]  core_cal_offset,
    output reg  [7:0]  core_cal_gain,
    input  wire [11:0] core_result,
    output wire        mem_valid,
    input  wire        mem_ready,
    output wire [15:0] mem_data,
    output reg  [23:0] mem_addr
);
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_PWR  = 4'h2;
    localparam [3:0] S_ACQ  = 4'h4;
    localparam [3:0] S_CONV = 4'h8;
    reg  [7:0]  adc_timing_mode_control;
    reg         conversion_done_flag;
    reg         stream_mode_bit;
    reg         continuous_convert_bit;
    reg         single_convert_bit;
    reg  [3:0]  channel_select_field;
    reg  [11:0] result_word;
    reg  [3:0]  result_chan;
    reg         cal_load_pending;
    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [2:0]  div_cnt;
    reg  [4:0]  tick_cnt;
    reg         pin_s1;
    reg         pin_s2;
    reg         pin_s3;
    reg         pin_level;
    reg         finish;
    wire [1:0]  power_mode;
    wire [2:0]  div_last;
    wire [4:0]  acq_clks;
    wire        pin_fall;
    wire        trigger;
    wire        fifo_ready;
    wire        stream_wrap;

    assign power_mode = adc_timing_mode_control[`ADCC_TMC_MODE_HI:`ADCC_TMC_MODE_LO];
    assign div_last = (3'h1 << {adc_timing_mode_control[`ADCC_TMC_DIV_HI],
                                adc_timing_mode_control[`ADCC_TMC_DIV_LO]}) - 3'h1;
    assign acq_clks = {1'b0, 4'h1 << {adc_timing_mode_control[`ADCC_TMC_ACQ_HI],
                                      adc_timing_mode_control[`ADCC_TMC_ACQ_LO]}};
    assign irq_req = conversion_done_flag;
    assign stream_wrap = stream_mode_bit & mem_valid & mem_ready & (mem_addr == `ADCC_ADDR_LAST);

    // ----------------------------------------
    // Convert pin: three stages, change accepted when stages two and three agree
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1    <= 1'b1;
            pin_s2    <= 1'b1;
            pin_s3    <= 1'b1;
            pin_level <= 1'b1;
        end
        else
        begin
            pin_s1 <= external_convert_start_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3)
                pin_level <= pin_s3;
        end
    end

    // One start per low pulse, so a held-low pin does not retrigger
    assign pin_fall = pin_level & ~pin_s3 & ~pin_s2;
    // Triggers are only looked at while idle; a full FIFO stalls streaming
    assign trigger = (state == S_IDLE) && (power_mode != `ADCC_MODE_DOWN) && fifo_ready &&
                     (single_convert_bit || continuous_convert_bit || stream_mode_bit ||
                      (adc_timing_mode_control[`ADCC_TMC_TIMER] && timer_overflow) ||
                      (adc_timing_mode_control[`ADCC_TMC_PIN] && pin_fall));

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @*
    begin
        next_state = state;
        finish     = 1'b0;
        case (state)
            S_IDLE:
                if (trigger)
                    next_state = (power_mode == `ADCC_MODE_NORMAL) ? S_ACQ : S_PWR;
            S_PWR:
                if (core_clk_tick && tick_cnt == {1'b0, `ADCC_PWRUP_CLKS} - 5'h1)
                    next_state = S_ACQ;
            S_ACQ:
                if (core_clk_tick && tick_cnt == acq_clks - 5'h1)
                    next_state = S_CONV;
            S_CONV:
                if (core_clk_tick && tick_cnt == `ADCC_CONV_CLKS - 5'h1)
                begin
                    next_state = S_IDLE;
                    finish     = 1'b1;
                end
            default:
                next_state = S_IDLE;
        endcase
    end

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state         <= S_IDLE;
            div_cnt       <= 3'h0;
            tick_cnt      <= 5'h0;
            core_clk_tick <= 1'b0;
            core_mux_sel  <= 4'h0;
            result_word   <= 12'h000;
            result_chan   <= 4'h0;
        end
        else
        begin
            state <= next_state;
            if (state == S_IDLE || div_cnt >= div_last)
                div_cnt <= 3'h0;
            else
                div_cnt <= div_cnt + 3'h1;
            core_clk_tick <= (state != S_IDLE) && (div_cnt >= div_last);
            if (next_state != state)
                tick_cnt <= 5'h0;
            else if (core_clk_tick)
                tick_cnt <= tick_cnt + 5'h1;
            if (trigger)
                core_mux_sel <= channel_select_field;
            if (finish)
            begin
                result_word <= core_result;
                result_chan <= core_mux_sel;
            end
        end
    end

    // ----------------------------------------
    // Power and core strobes
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            core_power_on <= 1'b0;
            core_ref_on   <= 1'b0;
            core_track    <= 1'b0;
            core_convert  <= 1'b0;
        end
        else
        begin
            core_power_on <= (power_mode == `ADCC_MODE_NORMAL) || (next_state != S_IDLE);
            core_ref_on   <= (power_mode == `ADCC_MODE_NORMAL) ||
                             (power_mode == `ADCC_MODE_STBYIDL) || (next_state != S_IDLE);
            core_track    <= (next_state == S_ACQ);
            core_convert  <= (next_state == S_CONV);
        end
    end

    // ----------------------------------------
    // Function registers
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            adc_timing_mode_control <= `ADCC_TMC_RESET;
            conversion_done_flag    <= 1'b0;
            stream_mode_bit         <= 1'b0;
            continuous_convert_bit  <= 1'b0;
            single_convert_bit      <= 1'b0;
            channel_select_field    <= 4'h0;
            core_cal_offset         <= 8'h00;
            core_cal_gain           <= 8'h00;
            cal_load_pending        <= 1'b1;
        end
        else
        begin
            // Factory values are sampled on the first edge after reset release
            if (cal_load_pending)
            begin
                core_cal_offset  <= factory_offset;
                core_cal_gain    <= factory_gain;
                cal_load_pending <= 1'b0;
            end
            else if (sfr_wr && sfr_addr == `ADCC_ADDR_OFFS)
                core_cal_offset <= sfr_wdata;
            else if (sfr_wr && sfr_addr == `ADCC_ADDR_GAIN)
                core_cal_gain <= sfr_wdata;
            if (sfr_wr && sfr_addr == `ADCC_ADDR_TMC)
                adc_timing_mode_control <= sfr_wdata;
            if (sfr_wr && sfr_addr == `ADCC_ADDR_CTL)
            begin
                stream_mode_bit        <= sfr_wdata[`ADCC_CTL_STREAM];
                continuous_convert_bit <= sfr_wdata[`ADCC_CTL_CONT];
                channel_select_field   <= sfr_wdata[3:0];
            end
            else if (stream_wrap)
                stream_mode_bit <= 1'b0;
            // Completion clears the start bit even against a same-cycle rewrite
            if (finish)
                single_convert_bit <= 1'b0;
            else if (sfr_wr && sfr_addr == `ADCC_ADDR_CTL)
                single_convert_bit <= sfr_wdata[`ADCC_CTL_SINGLE];
            // Hardware set beats a same-cycle clear
            if ((finish && !stream_mode_bit) || stream_wrap)
                conversion_done_flag <= 1'b1;
            else if (irq_ack)
                conversion_done_flag <= 1'b0;
            else if (sfr_wr && sfr_addr == `ADCC_ADDR_CTL)
                conversion_done_flag <= sfr_wdata[`ADCC_CTL_DONE];
        end
    end
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            sfr_rdata <= 8'h00;
        else
            case (sfr_addr)
                `ADCC_ADDR_TMC:  sfr_rdata <= adc_timing_mode_control;
                `ADCC_ADDR_CTL:  sfr_rdata <= {conversion_done_flag, stream_mode_bit,
                                               continuous_convert_bit, single_convert_bit,
                                               channel_select_field};
                `ADCC_ADDR_RESH: sfr_rdata <= {result_chan, result_word[11:8]};
                `ADCC_ADDR_RESL: sfr_rdata <= result_word[7:0];
                `ADCC_ADDR_OFFS: sfr_rdata <= core_cal_offset;
                `ADCC_ADDR_GAIN: sfr_rdata <= core_cal_gain;
                default:         sfr_rdata <= 8'h00;
            endcase
    end

    // ----------------------------------------
    // Streaming path to external memory
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            mem_addr <= 24'h000000;
        else if (sfr_wr && sfr_addr == `ADCC_ADDR_CTL && sfr_wdata[`ADCC_CTL_STREAM] &&
                 !stream_mode_bit)
            mem_addr <= 24'h000000;
        else if (mem_valid && mem_ready)
            mem_addr <= mem_addr + 24'h000001;
    end
    adcc_fifo #(.WIDTH(16), .DEPTH(8), .AW(3)) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (finish & stream_mode_bit),
        .in_ready  (fifo_ready),
        .in_data   ({core_mux_sel, core_result}),
        .out_valid (mem_valid),
        .out_ready (mem_ready),
        .out_data  (mem_data)
    );
endmodule // adcc_ctrl
`default_nettype wire

/* test/adcc_core_model.sv */
// Behavioural converter core answering with a channel-tagged code
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model (
    input  wire logic        clk_sys,
    input  wire logic        core_power_on,
    input  wire logic        core_convert,
    input  wire logic [3:0]  core_mux_sel,
    output var  logic [11:0] core_result
);
    logic [11:0] junk = 12'h0f0;

    always @(posedge clk_sys)
        junk <= ~junk;

    // An idle or unpowered core toggles, so a sample taken at the wrong time shows
    assign core_result = (core_convert && core_power_on) ?
                         12'h5a0 + {8'h00, core_mux_sel} : junk;
endmodule // adcc_core_model
`default_nettype wire

/* test/adcc_ctrl_chk.sv */
// Port checker for the converter controller
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defs.vh"
module adcc_ctrl_chk (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       irq_ack,
    input wire logic       irq_req,
    input wire logic       core_power_on,
    input wire logic       core_ref_on,
    input wire logic       core_clk_tick,
    input wire logic       core_track,
    input wire logic       core_convert,
    input wire logic [3:0] core_mux_sel
);
    logic [7:0] tmc;
    logic [4:0] n_cv;
    logic [3:0] n_tr;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    always_ff @(posedge clk_sys or negedge nrst)
        if (!nrst)
            tmc <= `ADCC_TMC_RESET;
        else if (sfr_wr && sfr_addr == `ADCC_ADDR_TMC)
            tmc <= sfr_wdata;

    // Converter clocks seen in acquisition and in conversion
    always_ff @(posedge clk_sys)
    begin
        n_cv <= core_convert ? n_cv + 5'(core_clk_tick) : 5'd0;
        n_tr <= core_track ? n_tr + 4'(core_clk_tick) : 4'd0;
    end

    a_conv_len: assert property ($fell(core_convert) |-> n_cv == 5'd17)
        else $error("conversion length wrong");
    a_acq_len: assert property ($fell(core_track) |-> n_tr == (4'd1 << tmc[3:2]))
        else $error("acquisition length wrong");
    a_tmc_read: assert property (sfr_addr == `ADCC_ADDR_TMC && !sfr_wr |=> sfr_rdata == tmc)
        else $error("mode register read wrong");
    a_ack_clears: assert property (irq_ack && !core_convert && !sfr_wr |=> !irq_req)
        else $error("done flag not cleared");
    a_done_cause: assert property ($rose(irq_req) |->
        $past(sfr_wr) || $past(core_convert) || $past(core_convert, 2))
        else $error("done flag without conversion");
    a_down_off: assert property (tmc[7:6] == 2'd0 && $past(tmc[7:6]) == 2'd0
        |=> !core_power_on && !core_ref_on)
        else $error("powered in off mode");
    a_stby_ref: assert property (tmc[7:6] == 2'd3 && $past(tmc[7:6]) == 2'd3
        |=> core_ref_on)
        else $error("reference off in standby");
    a_mux_hold: assert property (core_convert && $past(core_convert) |-> $stable(core_mux_sel))
        else $error("channel moved in conversion");
    a_tick_b2b: assert property (core_clk_tick && $past(core_clk_tick) |-> tmc[5:4] == 2'd0)
        else $error("converter clock not divided");
    a_div8_gap: assert property (core_clk_tick && tmc[5:4] == 2'd3 |=> !core_clk_tick [*7])
        else $error("divide by eight too fast");

    c_conv: cover property ($fell(core_convert));
    c_done: cover property ($rose(irq_req));
    c_stby: cover property (tmc[7:6] == 2'd3 && core_convert);
endmodule // adcc_ctrl_chk

bind adcc_ctrl adcc_ctrl_chk i_chk (.clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack),
    .irq_req(irq_req), .core_power_on(core_power_on), .core_ref_on(core_ref_on),
    .core_clk_tick(core_clk_tick), .core_track(core_track), .core_convert(core_convert),
    .core_mux_sel(core_mux_sel));
`default_nettype wire

/* test/tb_adc_conversion_control.sv */
// Self-checking bench for the converter controller
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defs.vh"
module tb_adc_conversion_control;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        irq_ack = 1'b0;
    logic        tmr = 1'b0;
    logic        ext_n = 1'b1;
    logic        mem_ready = 1'b1;
    logic [7:0]  sfr_rdata, cal_off, cal_gain;
    logic        irq_req, pwr, ref_on, tick, track, conv, mem_valid;
    logic [3:0]  mux;
    logic [11:0] res;
    logic [15:0] mem_data;
    logic [23:0] mem_addr;
    int          errors = 0;
    int          n_checks = 0;

    initial forever #4 clk_sys = ~clk_sys;

    adcc_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack), .irq_req(irq_req),
        .timer_overflow(tmr), .external_convert_start_n(ext_n), .factory_offset(8'h3c),
        .factory_gain(8'hc3), .core_power_on(pwr), .core_ref_on(ref_on), .core_clk_tick(tick),
        .core_track(track), .core_convert(conv), .core_mux_sel(mux), .core_cal_offset(cal_off),
        .core_cal_gain(cal_gain), .core_result(res), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .mem_data(mem_data), .mem_addr(mem_addr));
    adcc_core_model i_core (.clk_sys(clk_sys), .core_power_on(pwr), .core_convert(conv),
        .core_mux_sel(mux), .core_result(res));

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        step(1);
        sfr_wr = 1'b0;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
        step(1);
        sfr_addr = a;
        step(1);
        chk(nm, sfr_rdata, e);
    endtask

    task automatic wait_done();
        for (int i = 0; i < 3000 && irq_req !== 1'b1; i++)
            step(1);
        chk("done flag", irq_req, 1'b1);
    endtask

    task automatic ack();
        step(1);
        irq_ack = 1'b1;
        step(1);
        irq_ack = 1'b0;
        chk("ack clears flag", irq_req, 1'b0);
    endtask

    task automatic pulse_timer();
        step(1);
        tmr = 1'b1;
        step(1);
        tmr = 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rc("mode reg", `ADCC_ADDR_TMC, 8'h20);
        rc("control reg", `ADCC_ADDR_CTL, 8'h00);
        rc("unmapped", 8'h80, 8'h00);
        chk("factory offset", cal_off, 8'h3c);
        chk("factory gain", cal_gain, 8'hc3);
        wr(`ADCC_ADDR_OFFS, 8'h11);
        wr(`ADCC_ADDR_GAIN, 8'h22);
        chk("user offset", cal_off, 8'h11);
        chk("user gain", cal_gain, 8'h22);
        $display("test reset done");
    endtask

    task automatic t_single();
        logic [3:0] ch;
        for (int c = 0; c < 4; c++)
        begin
            ch = (c == 3) ? 4'h8 : 4'(c * 3);
            wr(`ADCC_ADDR_TMC, {2'b01, 2'(c), 2'(3 - c), 2'b00});
            wr(`ADCC_ADDR_CTL, {4'h1, ch});
            wait_done();
            rc("result high", `ADCC_ADDR_RESH, {ch, 4'h5});
            rc("result low", `ADCC_ADDR_RESL, 8'ha0 + {4'h0, ch});
            rc("single cleared", `ADCC_ADDR_CTL, {4'h8, ch});
            ack();
        end
        $display("test single done");
    endtask

    task automatic t_modes();
        wr(`ADCC_ADDR_TMC, 8'h00);
        wr(`ADCC_ADDR_CTL, 8'h10);
        step(200);
        chk("off mode start", irq_req, 1'b0);
        wr(`ADCC_ADDR_CTL, 8'h00);
        for (int m = 2; m < 4; m++)
        begin
            wr(`ADCC_ADDR_TMC, {2'(m), 6'h00});
            wr(`ADCC_ADDR_CTL, 8'h12);
            wait_done();
            rc("idle mode result", `ADCC_ADDR_RESL, 8'ha2);
            step(4);
            chk("power after", pwr, 1'b0);
            chk("reference after", ref_on, m == 3);
            ack();
        end
        $display("test modes done");
    endtask

    task automatic t_triggers();
        wr(`ADCC_ADDR_TMC, 8'h72);
        pulse_timer();
        step(6);
        pulse_timer();
        wait_done();
        ack();
        step(300);
        chk("retrigger ignored", irq_req, 1'b0);
        wr(`ADCC_ADDR_TMC, 8'h70);
        pulse_timer();
        step(200);
        chk("timer disabled", irq_req, 1'b0);
        wr(`ADCC_ADDR_TMC, 8'h41);
        ext_n = 1'b0;
        step(4);
        ext_n = 1'b1;
        wait_done();
        ack();
        $display("test triggers done");
    endtask

    task automatic t_cont();
        int n;
        n = 0;
        wr(`ADCC_ADDR_TMC, 8'h40);
        wr(`ADCC_ADDR_CTL, 8'h23);
        wait_done();
        ack();
        wait_done();
        rc("continuous result", `ADCC_ADDR_RESL, 8'ha3);
        wr(`ADCC_ADDR_CTL, 8'h00);
        step(40);
        ack();
        mem_ready = 1'b0;
        wr(`ADCC_ADDR_CTL, 8'h65);
        step(600);
        chk("no flag per sample", irq_req, 1'b0);
        wr(`ADCC_ADDR_CTL, 8'h00);
        mem_ready = 1'b1;
        while (mem_valid === 1'b1 && n < 20)
        begin
            chk("stream word", mem_data, 16'h55a5);
            chk("stream addr", mem_addr, 24'(n));
            n++;
            step(1);
        end
        chk("words buffered", 24'(n), 24'd8);
        $display("test continuous done");
    endtask

    initial
    begin
        step(8);
        nrst = 1'b1;
        step(2);
        t_reset();
        t_single();
        t_modes();
        t_triggers();
        t_cont();
        give_verdict();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
endmodule // tb_adc_conversion_control
`default_nettype wire
